// ==== pmr_regs_map.svh ====
/*
 * Register offsets, field positions, command codes, reset values and timing
 * counts of the margin command register bank.
 * Assumes a 100 MHz mclk and a bus target reached over two wires.
 */
// How it works
// R01: trim code stored in bits 11..2 only
// R02: straight binary; 8-bit variant drops two LSBs
// R03: command 00h turns the output off
// R04: command 80h turns the output on
// R05: command A4h drives output to upper trim
// R06: command 94h drives output to lower trim
// R07: timeout, bad length, unpointed read set fault
// R08: fault stays until host writes one
// R09: revision register reads 2200h, read-only
// R10: four target addresses chosen by strap pin
// R11: saved settings reload after power cycle
// R12: margin-low pending clears once code reached
// R13: output starts powered down unless storage says
// R14: unknown operation codes are ignored
`ifndef PMR_REGS_MAP_SVH
`define PMR_REGS_MAP_SVH

`define PMR_OFS_OPERATION  8'h01
`define PMR_OFS_DATA       8'h21
`define PMR_OFS_UPPER      8'h25
`define PMR_OFS_LOWER      8'h26
`define PMR_OFS_STATUS     8'h78
`define PMR_OFS_REVISION   8'h98

`define PMR_CMD_OFF        8'h00
`define PMR_CMD_ON         8'h80
`define PMR_CMD_HIGH       8'hA4
`define PMR_CMD_LOW        8'h94

`define PMR_REVISION_VALUE 16'h2200
`define PMR_CODE_RESET     10'h000
`define PMR_CODE_MSB       11
`define PMR_CODE_LSB       2
`define PMR_FAULT_BIT      9
`define PMR_EIGHT_BIT_MASK 10'h3FC
`define PMR_RAMP_STEPS     11'h400

`define PMR_TARGET_BASE    5'h12
`define PMR_BYTE_BITS      4'h8

`define PMR_TIMEOUT_MS     25
`define PMR_CLK_KHZ        100000
`define PMR_TIMEOUT_CYCLES (`PMR_TIMEOUT_MS * `PMR_CLK_KHZ)

`endif

// ==== pmr_pkg.sv ====
/*
 * Types of the margin command register bank.
 * Assumes pmr_regs_map.svh supplies all numeric constants except the state codes set here.
 */
package pmr_pkg;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK   = 7'h04,
        ST_WRITE = 7'h08,
        ST_TX    = 7'h10,
        ST_MACK  = 7'h20,
        ST_WAIT  = 7'h40
    } pmr_state_type;

    typedef struct packed {
        logic       startOn;
        logic [9:0] dataCode;
        logic [9:0] upperTrim;
        logic [9:0] lowerTrim;
    } pmr_nvm_image_type;

endpackage

// ==== pmr_margin_regs.sv ====
/*
 * Margin command register bank behind a two-wire bus target: operation
 * command, trim codes, sticky fault status and protocol revision.
 * Assumes scl/sda are already synchronous to mclk and that the storage
 * macro presents its saved image on nvmImage whenever reset is released.
 */
`include "pmr_regs_map.svh"

module pmr_margin_regs
    import pmr_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES    = `PMR_TIMEOUT_CYCLES,
    parameter bit          EIGHT_BIT_VARIANT = 1'b0
) (
    input  wire logic              mclk,             // system clock, 100 MHz
    input  wire logic              reset,            // async reset, active high
    input  wire logic              sclIn,            // bus clock level
    input  wire logic              sdaIn,            // bus data level
    output logic                   sdaOut,           // data drive value, always low
    output logic                   sdaOe,            // pull data low while high
    input  wire logic [1:0]        addressStrapPin,  // strap connection code
    input  wire pmr_nvm_image_type nvmImage,         // saved settings image
    output logic [9:0]             outputCode,       // code applied to converter
    output logic                   outputOn,         // converter output enabled
    output logic                   commFaultFlag,    // sticky fault flag
    output logic                   marginLowPending  // margin-low still ramping
);

    localparam logic [21:0] TIMEOUT_LAST = 22'(TIMEOUT_CYCLES - 1);

    function automatic logic [9:0] maskCode(input logic [9:0] c);
        maskCode = EIGHT_BIT_VARIANT ? (c & `PMR_EIGHT_BIT_MASK) : c;
    endfunction

    // ****************************************
    // bus line conditions
    // ****************************************
    logic          sclPrev_ff, sdaPrev_ff;
    logic          sclRise, sclFall, startCond, stopCond;
    pmr_state_type state_ff;
    logic [7:0]    shift_ff, ptr_ff, msb_ff, wrAddr_ff;
    logic [3:0]    bitCnt_ff;
    logic [1:0]    byteIdx_ff, addrSel_ff;
    logic          isRead_ff, ptrValid_ff, wrStrobe_ff, sdaOe_ff, sdaOut_ff;
    logic [15:0]   wrData_ff, txWord;
    logic [7:0]    txByte;
    logic [21:0]   lowCnt_ff;
    logic          timeoutHit, byteDone, addrMatch, readNoPtr, badLength, overLength;
    logic [7:0]    opCmd_ff;
    logic [9:0]    lowerTrim_ff, upperTrim_ff, dataCode_ff, outputCode_ff, target;
    logic          nvmDone_ff, fault_ff, outputOn_ff, lowPending_ff;
    logic          clearFault, cmdValid, faultEvent;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            sclPrev_ff <= sclIn;
            sdaPrev_ff <= sdaIn;
        end
    end

    assign sclRise   = sclIn & ~sclPrev_ff;
    assign sclFall   = ~sclIn & sclPrev_ff;
    assign startCond = sclIn & sclPrev_ff & sdaPrev_ff & ~sdaIn;
    assign stopCond  = sclIn & sclPrev_ff & ~sdaPrev_ff & sdaIn;
    assign byteDone  = sclFall & (bitCnt_ff == `PMR_BYTE_BITS);
    // R10 strap address
    assign addrMatch = (shift_ff[7:1] == {`PMR_TARGET_BASE, addrSel_ff});
    // R07 fault causes
    assign readNoPtr  = (state_ff == ST_ADDR) & byteDone & addrMatch & shift_ff[0] & ~ptrValid_ff;
    // the stop's own clock rise counts one bit; only more than that is a cut byte
    assign badLength  = stopCond & (state_ff == ST_WRITE) & ((bitCnt_ff > 4'h1) | (byteIdx_ff == 2'h2));
    assign overLength = (state_ff == ST_WRITE) & byteDone & (byteIdx_ff == 2'h3);
    assign timeoutHit = (lowCnt_ff == TIMEOUT_LAST);

    // ****************************************
    // bus timeout
    // ****************************************
    // held-low clock only counts inside a transfer, idle bus never faults
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lowCnt_ff <= 22'h00_0000;
        end else if (sclIn || state_ff == ST_IDLE || timeoutHit) begin
            lowCnt_ff <= 22'h00_0000;
        end else begin
            lowCnt_ff <= lowCnt_ff + 22'h00_0001;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        txWord = 16'h0000;
        case (ptr_ff)
            `PMR_OFS_OPERATION: txWord = {opCmd_ff, 8'h00};
            `PMR_OFS_STATUS:    txWord[`PMR_FAULT_BIT] = fault_ff;
            // R09 fixed revision
            `PMR_OFS_REVISION:  txWord = `PMR_REVISION_VALUE;
            default:            txWord = 16'h0000;
        endcase
        case (byteIdx_ff)
            2'h0:    txByte = txWord[15:8];
            2'h1:    txByte = txWord[7:0];
            default: txByte = 8'h00;
        endcase
    end

    // ****************************************
    // bus target sequencer
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_ff    <= ST_IDLE;
            shift_ff    <= 8'h00;
            bitCnt_ff   <= 4'h0;
            byteIdx_ff  <= 2'h0;
            isRead_ff   <= 1'b0;
            ptrValid_ff <= 1'b0;
            ptr_ff      <= 8'h00;
            msb_ff      <= 8'h00;
            wrStrobe_ff <= 1'b0;
            wrAddr_ff   <= 8'h00;
            wrData_ff   <= 16'h0000;
            sdaOe_ff    <= 1'b0;
            sdaOut_ff   <= 1'b0;
        end else begin
            wrStrobe_ff <= 1'b0;
            sdaOut_ff   <= 1'b0;
            if (timeoutHit) begin
                state_ff <= ST_IDLE;
                sdaOe_ff <= 1'b0;
            end else if (startCond) begin
                // repeated start keeps the pointer for the read that follows
                state_ff   <= ST_ADDR;
                bitCnt_ff  <= 4'h0;
                byteIdx_ff <= 2'h0;
                sdaOe_ff   <= 1'b0;
            end else if (stopCond) begin
                state_ff    <= ST_IDLE;
                sdaOe_ff    <= 1'b0;
                ptrValid_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_ADDR, ST_WRITE: begin
                        if (sclRise) begin
                            shift_ff  <= {shift_ff[6:0], sdaIn};
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (byteDone) begin
                            bitCnt_ff <= 4'h0;
                            if (state_ff == ST_ADDR) begin
                                // R10 foreign address
                                if (!addrMatch || readNoPtr) begin
                                    state_ff <= ST_WAIT;
                                end else begin
                                    state_ff  <= ST_ACK;
                                    sdaOe_ff  <= 1'b1;
                                    isRead_ff <= shift_ff[0];
                                end
                            end else begin
                                state_ff <= ST_ACK;
                                sdaOe_ff <= 1'b1;
                                if (byteIdx_ff != 2'h3) begin
                                    byteIdx_ff <= byteIdx_ff + 2'h1;
                                end
                                if (byteIdx_ff == 2'h0) begin
                                    ptr_ff      <= shift_ff;
                                    ptrValid_ff <= 1'b1;
                                end
                                if (byteIdx_ff == 2'h1) begin
                                    msb_ff <= shift_ff;
                                end
                                if (byteIdx_ff == 2'h2) begin
                                    wrStrobe_ff <= 1'b1;
                                    wrAddr_ff   <= ptr_ff;
                                    wrData_ff   <= {msb_ff, shift_ff};
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            if (isRead_ff) begin
                                state_ff  <= ST_TX;
                                sdaOe_ff  <= ~txByte[7];
                                shift_ff  <= {txByte[6:0], 1'b0};
                                bitCnt_ff <= 4'h0;
                            end else begin
                                state_ff <= ST_WRITE;
                                sdaOe_ff <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (sclRise) begin
                            bitCnt_ff <= bitCnt_ff + 4'h1;
                        end else if (byteDone) begin
                            state_ff  <= ST_MACK;
                            sdaOe_ff  <= 1'b0;
                            bitCnt_ff <= 4'h0;
                            if (byteIdx_ff != 2'h3) begin
                                byteIdx_ff <= byteIdx_ff + 2'h1;
                            end
                        end else if (sclFall) begin
                            sdaOe_ff <= ~shift_ff[7];
                            shift_ff <= {shift_ff[6:0], 1'b0};
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            state_ff <= sdaIn ? ST_WAIT : ST_ACK;
                        end
                    end
                    ST_IDLE, ST_WAIT: state_ff <= state_ff;
                    default:          state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // register file and storage reload
    // ****************************************
    assign cmdValid = (wrData_ff[15:8] == `PMR_CMD_OFF) | (wrData_ff[15:8] == `PMR_CMD_ON) |
                      (wrData_ff[15:8] == `PMR_CMD_HIGH) | (wrData_ff[15:8] == `PMR_CMD_LOW);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            nvmDone_ff   <= 1'b0;
            addrSel_ff   <= 2'h0;
            opCmd_ff     <= `PMR_CMD_OFF;
            lowerTrim_ff <= `PMR_CODE_RESET;
            upperTrim_ff <= `PMR_CODE_RESET;
            dataCode_ff  <= `PMR_CODE_RESET;
        end else if (!nvmDone_ff) begin
            // R11 reload saved image
            nvmDone_ff   <= 1'b1;
            addrSel_ff   <= addressStrapPin;
            lowerTrim_ff <= maskCode(nvmImage.lowerTrim);
            upperTrim_ff <= maskCode(nvmImage.upperTrim);
            dataCode_ff  <= maskCode(nvmImage.dataCode);
            // R13 default powered down
            opCmd_ff     <= nvmImage.startOn ? `PMR_CMD_ON : `PMR_CMD_OFF;
        end else if (wrStrobe_ff) begin
            case (wrAddr_ff)
                // R03 R04 R05 R06 R14 accept known codes only
                `PMR_OFS_OPERATION: if (cmdValid) opCmd_ff <= wrData_ff[15:8];
                // R01 R02 trim field
                `PMR_OFS_LOWER: lowerTrim_ff <= maskCode(wrData_ff[`PMR_CODE_MSB:`PMR_CODE_LSB]);
                `PMR_OFS_UPPER: upperTrim_ff <= maskCode(wrData_ff[`PMR_CODE_MSB:`PMR_CODE_LSB]);
                `PMR_OFS_DATA:  dataCode_ff  <= maskCode(wrData_ff[`PMR_CODE_MSB:`PMR_CODE_LSB]);
                default:        dataCode_ff  <= dataCode_ff;
            endcase
        end
    end

    // ****************************************
    // sticky fault
    // ****************************************
    assign faultEvent = readNoPtr | badLength | overLength | timeoutHit;
    assign clearFault = wrStrobe_ff & (wrAddr_ff == `PMR_OFS_STATUS) & wrData_ff[`PMR_FAULT_BIT];

    // R07 R08 set wins over clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= faultEvent | (fault_ff & ~clearFault);
        end
    end

    // ****************************************
    // output control
    // ****************************************
    always_comb begin
        case (opCmd_ff)
            `PMR_CMD_HIGH: target = upperTrim_ff;
            `PMR_CMD_LOW:  target = lowerTrim_ff;
            default:       target = dataCode_ff;
        endcase
    end

    // one code step per clock keeps the margin transition monotonic
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            outputCode_ff <= `PMR_CODE_RESET;
            outputOn_ff   <= 1'b0;
        end else begin
            // R03 R04 output enable
            outputOn_ff <= (opCmd_ff != `PMR_CMD_OFF);
            // R05 R06 move toward trim
            if (outputCode_ff < target) begin
                outputCode_ff <= outputCode_ff + 10'h001;
            end else if (outputCode_ff > target) begin
                outputCode_ff <= outputCode_ff - 10'h001;
            end
        end
    end

    // R12 self-clearing pending bit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lowPending_ff <= 1'b0;
        end else if (wrStrobe_ff && wrAddr_ff == `PMR_OFS_OPERATION && wrData_ff[15:8] == `PMR_CMD_LOW) begin
            lowPending_ff <= 1'b1;
        end else if (opCmd_ff == `PMR_CMD_LOW && outputCode_ff == lowerTrim_ff) begin
            lowPending_ff <= 1'b0;
        end
    end

    assign sdaOut           = sdaOut_ff;
    assign sdaOe            = sdaOe_ff;
    assign outputCode       = outputCode_ff;
    assign outputOn         = outputOn_ff;
    assign commFaultFlag    = fault_ff;
    assign marginLowPending = lowPending_ff;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic wrOp, wrLow;
    assign wrOp  = wrStrobe_ff & nvmDone_ff & (wrAddr_ff == `PMR_OFS_OPERATION);
    assign wrLow = wrStrobe_ff & nvmDone_ff & (wrAddr_ff == `PMR_OFS_LOWER);

    // R05 R06 ramp watchdogs
    // a full-scale ramp is longer than a delay range may reach, so count it here
    logic [10:0] rampHighCnt_ff, rampLowCnt_ff;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rampHighCnt_ff <= 11'h000;
            rampLowCnt_ff  <= 11'h000;
        end else begin
            rampHighCnt_ff <= (wrStrobe_ff || opCmd_ff != `PMR_CMD_HIGH || outputCode_ff == upperTrim_ff) ?
                              11'h000 : rampHighCnt_ff + 11'h001;
            rampLowCnt_ff  <= (wrStrobe_ff || opCmd_ff != `PMR_CMD_LOW || outputCode_ff == lowerTrim_ff) ?
                              11'h000 : rampLowCnt_ff + 11'h001;
        end
    end

    property p_trim_store;
        wrLow |=> lowerTrim_ff == maskCode($past(wrData_ff[`PMR_CODE_MSB:`PMR_CODE_LSB]));
    endproperty
    a_trim_store: assert property (p_trim_store) else $error("lower trim not stored"); // R01
    property p_eight_bit;
        EIGHT_BIT_VARIANT == 1'b0 || (lowerTrim_ff[1:0] == 2'h0 && upperTrim_ff[1:0] == 2'h0);
    endproperty
    a_eight_bit: assert property (p_eight_bit) else $error("8-bit low bits kept"); // R02
    property p_off;
        wrOp && wrData_ff[15:8] == `PMR_CMD_OFF |=> ##1 !outputOn_ff;
    endproperty
    a_off: assert property (p_off) else $error("output not turned off"); // R03
    property p_on;
        wrOp && wrData_ff[15:8] == `PMR_CMD_ON |=> ##1 outputOn_ff;
    endproperty
    a_on: assert property (p_on) else $error("output not turned on"); // R04
    property p_high;
        rampHighCnt_ff < `PMR_RAMP_STEPS;
    endproperty
    a_high: assert property (p_high) else $error("upper trim not reached"); // R05
    property p_low;
        rampLowCnt_ff < `PMR_RAMP_STEPS;
    endproperty
    a_low: assert property (p_low) else $error("lower trim not reached"); // R06
    property p_fault_set;
        readNoPtr || badLength || timeoutHit |=> fault_ff;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not raised"); // R07
    property p_fault_hold;
        fault_ff && !clearFault |=> fault_ff;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped without clear"); // R08
    property p_revision;
        ptr_ff == `PMR_OFS_REVISION |-> txWord == `PMR_REVISION_VALUE;
    endproperty
    a_revision: assert property (p_revision) else $error("revision word wrong"); // R09
    property p_foreign;
        state_ff == ST_ADDR && byteDone && !addrMatch && !startCond && !stopCond && !timeoutHit
            |=> state_ff == ST_WAIT && !sdaOe_ff;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acknowledged"); // R10
    property p_reload;
        $rose(nvmDone_ff) |-> lowerTrim_ff == maskCode($past(nvmImage.lowerTrim));
    endproperty
    a_reload: assert property (p_reload) else $error("saved trim not reloaded"); // R11
    property p_pending_clear;
        lowPending_ff && opCmd_ff == `PMR_CMD_LOW && outputCode_ff == lowerTrim_ff && !wrOp |=> !lowPending_ff;
    endproperty
    a_pending_clear: assert property (p_pending_clear) else $error("pending bit stuck"); // R12
    property p_startup;
        $rose(nvmDone_ff) |-> opCmd_ff == ($past(nvmImage.startOn) ? `PMR_CMD_ON : `PMR_CMD_OFF);
    endproperty
    a_startup: assert property (p_startup) else $error("startup state wrong"); // R13
    property p_ignore;
        wrOp && !cmdValid |=> $stable(opCmd_ff);
    endproperty
    a_ignore: assert property (p_ignore) else $error("unknown command accepted"); // R14

    c_revision_read: cover property (state_ff == ST_TX && ptr_ff == `PMR_OFS_REVISION);
    c_low_reached:   cover property ($fell(lowPending_ff));
    c_fault_clear:   cover property (fault_ff && clearFault);
    c_timeout:       cover property (timeoutHit);
endmodule

// ==== pmr_host_model.sv ====
/* Two-wire bus host model: start/stop conditions, byte write, byte read.
   Assumes the bench resolves sda with a pull-up from all pull enables. */
module pmr_host_model (
    input  wire logic mclk,    // bench clock
    input  wire logic sda,     // resolved data line
    output logic      scl,     // bus clock, stands high outside frames
    output logic      sdaPull  // high pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // bus tasks
    // ********
    initial begin
        scl = 1'h1;
        sdaPull = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // data moves only while scl low; start and stop move it while high
    task automatic cond(input logic p0, input logic p1, input logic s1);
        tick(1);
        sdaPull <= p0;
        tick(2);
        scl <= 1'h1;
        tick(4);
        sdaPull <= p1;
        tick(4);
        scl <= s1;
    endtask

    task automatic bitx(input logic b, output logic r);
        tick(1);
        sdaPull <= ~b;
        tick(3);
        scl <= 1'h1;
        tick(3);
        r = sda;
        scl <= 1'h0;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'h1, r);
        ack = ~r;
    endtask

    // last byte is answered with a nack so the device lets go
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'h1, d[i]);
        bitx(last, r);
    endtask
endmodule

// ==== test_pmbus_margin_command_regs.sv ====
/* Self-checking bench of the margin command register bank.
   Assumes pmr_host_model as bus host; sda is pulled up when released. */
`include "pmr_regs_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_pmbus_margin_command_regs
    import pmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // harness
    // ********
    logic              mclk, reset, scl, pull, sdaOe, sdaOe8, sdaOut, sda, on, fault, lowPend, ack;
    logic [1:0]        strap;
    logic [6:0]        adr;
    pmr_nvm_image_type nvm;
    logic [9:0]        code, code8, want, lo, hi, dat;
    logic [7:0]        op;
    logic [15:0]       seed, w;
    int                bad_count, check_count, cyc;
    logic [7:0]        ops [5] = '{`PMR_CMD_ON, `PMR_CMD_LOW, `PMR_CMD_HIGH, 8'h55, `PMR_CMD_OFF};

    assign sda = ~(pull | (sdaOe & ~sdaOut) | sdaOe8);
    assign adr = {`PMR_TARGET_BASE, strap};

    pmr_host_model host (.mclk(mclk), .sda(sda), .scl(scl), .sdaPull(pull));
    pmr_margin_regs #(.TIMEOUT_CYCLES(200)) uut (.mclk(mclk), .reset(reset), .sclIn(scl), .sdaIn(sda),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addressStrapPin(strap), .nvmImage(nvm), .outputCode(code),
        .outputOn(on), .commFaultFlag(fault), .marginLowPending(lowPend));
    // 8-bit twin on the same bus and strap answers exactly like uut
    pmr_margin_regs #(.TIMEOUT_CYCLES(200), .EIGHT_BIT_VARIANT(1'b1)) uut8 (.mclk(mclk), .reset(reset),
        .sclIn(scl), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe8), .addressStrapPin(strap), .nvmImage(nvm),
        .outputCode(code8), .outputOn(), .commFaultFlag(), .marginLowPending());

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic head(input logic [7:0] b);
        host.cond(1'h0, 1'h1, 1'h0);
        host.wbyte(b, ack);
    endtask

    task automatic wr(input logic [6:0] da, input logic [7:0] p, input logic [15:0] d);
        head({da, 1'h0});
        `CHK(ack, da == adr)
        host.wbyte(p, ack);
        host.wbyte(d[15:8], ack);
        host.wbyte(d[7:0], ack);
        host.cond(1'h1, 1'h0, 1'h1);
    endtask

    task automatic rdchk(input logic [7:0] p, input logic [15:0] e);
        head({adr, 1'h0});
        host.wbyte(p, ack);
        head({adr, 1'h1});
        host.rbyte(1'h0, w[15:8]);
        host.rbyte(1'h1, w[7:0]);
        host.cond(1'h1, 1'h0, 1'h1);
        `CHK(w, e)
    endtask

    // fresh storage image on every reset
    task automatic do_reset(input logic [1:0] s);
        seed = lfsr(seed);
        @(posedge mclk);
        reset <= 1'h1;
        strap <= s;
        nvm <= {seed[0], seed[9:0], seed[15:6], seed[10:1]};
        repeat (5) @(posedge mclk);
        reset <= 1'h0;
        repeat (3) @(posedge mclk);
        dat = nvm.dataCode;
    endtask

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end

    // ********
    // tests
    // ********
    initial begin
        reset = 1'h1;
        strap = 2'h0;
        nvm = '0;
        seed = 16'h0025;
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            `CHK(on, nvm.startOn)
            if (nvm.startOn) repeat (1100) @(posedge mclk);
            if (nvm.startOn) `CHK(code, dat)
            if (nvm.startOn) `CHK(code8, dat & `PMR_EIGHT_BIT_MASK)
            rdchk(`PMR_OFS_OPERATION, {nvm.startOn, 15'h0000});
            wr({`PMR_TARGET_BASE, ~strap}, `PMR_OFS_DATA, 16'hFFFF);
            $display("startup and strap %0d done", s);
        end
        rdchk(`PMR_OFS_REVISION, 16'h2200);
        wr(adr, `PMR_OFS_REVISION, 16'hFFFF);
        rdchk(`PMR_OFS_REVISION, 16'h2200);
        seed = lfsr(seed);
        wr(adr, `PMR_OFS_LOWER, seed);
        lo = seed[11:2];
        rdchk(`PMR_OFS_LOWER, 16'h0000);
        seed = lfsr(seed);
        wr(adr, `PMR_OFS_UPPER, seed);
        hi = seed[11:2];
        // nominal half a scale off lower trim: margin-low still ramping when checked
        wr(adr, `PMR_OFS_DATA, {4'h0, lo ^ 10'h200, 2'h0});
        dat = lo ^ 10'h200;
        foreach (ops[i]) begin
            wr(adr, `PMR_OFS_OPERATION, {ops[i], 8'h00});
            if (ops[i] == `PMR_CMD_LOW) `CHK(lowPend, 1'h1)
            if (ops[i] != 8'h55) op = ops[i];
            repeat (1100) @(posedge mclk);
            `CHK(on, op != `PMR_CMD_OFF)
            want = op == `PMR_CMD_LOW ? lo : op == `PMR_CMD_HIGH ? hi : dat;
            if (op != `PMR_CMD_OFF) `CHK(code, want)
            if (op != `PMR_CMD_OFF) `CHK(code8, want & `PMR_EIGHT_BIT_MASK)
            `CHK(lowPend, 1'h0)
            rdchk(`PMR_OFS_OPERATION, {op, 8'h00});
        end
        $display("operation commands done");
        `CHK(fault, 1'h0)
        // word cut short after its first data byte
        head({adr, 1'h0});
        host.wbyte(`PMR_OFS_DATA, ack);
        host.wbyte(8'h12, ack);
        host.cond(1'h1, 1'h0, 1'h1);
        `CHK(fault, 1'h1)
        wr(adr, `PMR_OFS_STATUS, 16'h0000);
        rdchk(`PMR_OFS_STATUS, 16'h0200);
        wr(adr, `PMR_OFS_STATUS, 16'h0200);
        `CHK(fault, 1'h0)
        head({adr, 1'h1});
        `CHK(ack, 1'h0)
        host.cond(1'h1, 1'h0, 1'h1);
        `CHK(fault, 1'h1)
        wr(adr, `PMR_OFS_STATUS, 16'hFFFF);
        `CHK(fault, 1'h0)
        // host stalls with scl low past the timeout
        head({adr, 1'h0});
        repeat (250) @(posedge mclk);
        `CHK(fault, 1'h1)
        host.cond(1'h1, 1'h0, 1'h1);
        $display("fault tests done");
        end_sim();
    end
endmodule
